// >>> hw/hssm_pkg.sv
// package of constants for the high-side switch mode state machine
// assumes a 10 MHz system clock; all delays are counted in that clock
package hssm_pkg;
   // ****************************************
   // timing
   // ****************************************
   localparam int CLK_PERIOD_NS = 100;
   localparam int STANDBY_ENTRY_DELAY_US = 1000;
   localparam int STANDBY_ENTRY_DELAY_CYC = (STANDBY_ENTRY_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RETRY_TIME_US = 2000;
   localparam int RETRY_CYC = (RETRY_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SENSE_SETTLE_TIME_US = 150;
   localparam int SENSE_SETTLE_CYC = (SENSE_SETTLE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 16;

   // ****************************************
   // modes
   // ****************************************
   typedef enum logic [5:0] {
      HSSM_OFF      = 6'b00_0001,
      HSSM_SBY_DLY  = 6'b00_0010,
      HSSM_STANDBY  = 6'b00_0100,
      HSSM_DIAG     = 6'b00_1000,
      HSSM_ACTIVE   = 6'b01_0000,
      HSSM_FAULT    = 6'b10_0000
   } hssm_mode_t;

   // ****************************************
   // sense mux selections
   // ****************************************
   localparam logic [1:0] SNS_NONE = 2'h0;
   localparam logic [1:0] SNS_CURRENT = 2'h1;
   localparam logic [1:0] SNS_TEMP = 2'h2;
   localparam logic [1:0] SNS_FAULT = 2'h3;
endpackage

// >>> hw/hssm_sync.sv
// two-flip-flop synchroniser for a bundle of pin levels
// assumes the pins are asynchronous to clk_in
`timescale 1ns/1ps
`default_nettype none
module hssm_sync #(
   parameter int W = 1
) (
   input wire logic clk_in,          // system clock
   input wire logic rst_n_in,        // synchronous reset, active low
   input wire logic [W-1:0] d_in,    // asynchronous levels
   output logic [W-1:0] q_out        // synchronised levels
);
   logic [W-1:0] meta_reg;
   logic [W-1:0] sync_reg;

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         meta_reg <= '0;
         sync_reg <= '0;
      end else begin
         meta_reg <= d_in;
         sync_reg <= meta_reg;
      end
   end

   assign q_out = sync_reg;
endmodule
`default_nettype wire

// >>> hw/hssm_timer.sv
// down counter: loads on start, raises done while at zero
// assumes start is a one-cycle pulse or a level held while restarting
`timescale 1ns/1ps
`default_nettype none
module hssm_timer (
   input wire logic clk_in,                        // system clock
   input wire logic rst_n_in,                      // synchronous reset, active low
   input wire logic start_in,                      // reload the count
   input wire logic [hssm_pkg::CNT_W-1:0] load_in, // cycles to count
   output logic done_out                           // count has expired
);
   logic [hssm_pkg::CNT_W-1:0] cnt_reg;

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         cnt_reg <= '0;
      end else if (start_in) begin
         cnt_reg <= load_in;
      end else if (cnt_reg != '0) begin
         cnt_reg <= cnt_reg - 1'b1;
      end
   end

   assign done_out = (cnt_reg == '0) && !start_in;
endmodule
`default_nettype wire

// >>> hw/hssm_top.sv
// operating-mode state machine of a single-channel high-side power switch
// assumes host gpio drives the control pins; analog sensing is outside, selected by sense_sel_out
// Contract
// - without supply the block sits in off mode, no switching or diagnostics.
// - request and diag enable both low enters standby delay.
// - after standby delay, still both low, move to standby.
// - standby offers no diagnostics; sense and fault flag report nothing.
// - diagnostic mode runs diagnostics with the switch held off.
// - active mode keeps the power switch on.
// - diag enable toggles diagnostics in active mode without leaving it.
// - thermal shutdown or current limit enters fault mode.
// - leave fault only when faults clear, latch low, retry timer expired; here loss of supply or ground also leaves it, to off mode.
// - leaving fault with request high turns the switch back on.
// - leaving fault with request low keeps the switch off.
// - loss of ground turns the switch off or keeps it off.
// - after ground returns, operation resumes per inputs.
// - reverse current is no fault and changes no mode.
// - fixed-limit variant drives open-drain fault flag; board pulls it up.
// - open-load and short-to-supply detection only with diag high, request low.
// - latched fault indication clears on diag falling or request rising edge; the open-load indication here is not latched and follows the present level.
// - sense mux: off when diag low, else current, temperature or fault level.
// - fixed-limit variant pulls fault flag low in any fault condition while diag enable is high.
`timescale 1ns/1ps
`default_nettype none
module hssm_top #(
   parameter int STBY_CYC = hssm_pkg::STANDBY_ENTRY_DELAY_CYC,
   parameter int RETRY_CYC = hssm_pkg::RETRY_CYC,
   parameter bit FIXED_LIMIT = 1'b1
) (
   input wire logic clk_in,                 // system clock, 10 MHz
   input wire logic rst_n_in,               // synchronous reset, active low
   input wire logic supply_ok_in,           // supply present (pin)
   input wire logic gnd_ok_in,              // ground connected (pin)
   input wire logic switch_on_req_in,       // switch-on request (pin)
   input wire logic diag_enable_input_in,   // diagnostic enable (pin)
   input wire logic latch_in,               // fault latch (pin)
   input wire logic sense_source_select_in, // sense select (pin)
   input wire logic thermal_sd_in,          // thermal shutdown event (pin)
   input wire logic current_limit_in,       // current limit event (pin)
   input wire logic open_load_in,           // output above open-load threshold (pin)
   input wire logic reverse_current_in,     // reverse current seen (pin), ignored
   output logic switch_on_out,              // gate drive of the power switch
   output logic [5:0] mode_out,             // present mode, one-hot
   output logic sense_output_en_out,        // sense output drives
   output logic [1:0] sense_sel_out,        // sense source, see package
   output logic sense_valid_out,            // sense settled since turn-on
   output logic fault_flag_output_out,      // fault flag output level (always 0)
   output logic fault_flag_output_oe_out    // fault flag pulls low when high
);
   // ****************************************
   // pin synchronisation
   // ****************************************
   logic [9:0] pins_s;
   logic supply_s;
   logic gnd_s;
   logic req_s;
   logic diag_s;
   logic latch_s;
   logic sel_s;
   logic tsd_s;
   logic limit_set_pin_s;
   logic ol_s;
   logic rev_s;

   // all pins share one synchroniser, so their relative timing is kept
   hssm_sync #(.W(10)) u_sync (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .d_in({supply_ok_in,
             gnd_ok_in,
             switch_on_req_in,
             diag_enable_input_in,
             latch_in,
             sense_source_select_in,
             thermal_sd_in,
             current_limit_in,
             open_load_in,
             reverse_current_in}),
      .q_out(pins_s)
   );
   assign {supply_s, gnd_s, req_s, diag_s, latch_s, sel_s, tsd_s, limit_set_pin_s, ol_s, rev_s} = pins_s;

   // ****************************************
   // edge detection
   // ****************************************
   logic req_d_reg;
   logic diag_d_reg;
   logic req_rise;
   logic diag_fall;

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         req_d_reg <= 1'b0;
         diag_d_reg <= 1'b0;
      end else begin
         req_d_reg <= req_s;
         diag_d_reg <= diag_s;
      end
   end
   assign req_rise = req_s && !req_d_reg;
   assign diag_fall = !diag_s && diag_d_reg;

   // ****************************************
   // mode machine
   // ****************************************
   hssm_pkg::hssm_mode_t mode_reg;
   hssm_pkg::hssm_mode_t mode_next;
   logic powered;
   logic shutdown;
   logic stby_start;
   logic stby_done;
   logic retry_start;
   logic retry_done;
   logic fault_exit;

   // reverse current is deliberately never looked at beyond the synchroniser
   assign powered = supply_s && gnd_s;
   // reverse current is not a shutdown cause, so it can never move the mode
   assign shutdown = tsd_s || limit_set_pin_s;
   // exit needs every condition at once; a held latch keeps the part parked in fault
   assign fault_exit = !shutdown && !latch_s && retry_done;

   always_comb begin
      mode_next = mode_reg;
      case (mode_reg)
         hssm_pkg::HSSM_OFF: begin
            if (powered) begin
               mode_next = hssm_pkg::HSSM_SBY_DLY;
            end
         end
         hssm_pkg::HSSM_SBY_DLY: begin
            if (req_s) begin
               mode_next = hssm_pkg::HSSM_ACTIVE;
            end else if (diag_s) begin
               mode_next = hssm_pkg::HSSM_DIAG;
            end else if (stby_done) begin
               mode_next = hssm_pkg::HSSM_STANDBY;
            end
         end
         hssm_pkg::HSSM_STANDBY: begin
            if (req_s) begin
               mode_next = hssm_pkg::HSSM_ACTIVE;
            end else if (diag_s) begin
               mode_next = hssm_pkg::HSSM_DIAG;
            end
         end
         hssm_pkg::HSSM_DIAG: begin
            if (req_s) begin
               mode_next = hssm_pkg::HSSM_ACTIVE;
            end else if (!diag_s) begin
               mode_next = hssm_pkg::HSSM_SBY_DLY;
            end
         end
         hssm_pkg::HSSM_ACTIVE: begin
            // diag enable alone never moves us out of active
            if (shutdown) begin
               mode_next = hssm_pkg::HSSM_FAULT;
            end else if (!req_s && !diag_s) begin
               mode_next = hssm_pkg::HSSM_SBY_DLY;
            end else if (!req_s) begin
               mode_next = hssm_pkg::HSSM_DIAG;
            end
         end
         hssm_pkg::HSSM_FAULT: begin
            if (fault_exit) begin
               if (req_s) begin
                  mode_next = hssm_pkg::HSSM_ACTIVE;
               end else if (diag_s) begin
                  mode_next = hssm_pkg::HSSM_DIAG;
               end else begin
                  mode_next = hssm_pkg::HSSM_SBY_DLY;
               end
            end
         end
         default: begin
            mode_next = hssm_pkg::HSSM_OFF;
         end
      endcase
      // losing supply or ground overrides everything
      if (!powered) begin
         mode_next = hssm_pkg::HSSM_OFF;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         mode_reg <= hssm_pkg::HSSM_OFF;
      end else begin
         mode_reg <= mode_next;
      end
   end

   // ****************************************
   // timers
   // ****************************************
   assign stby_start = (mode_next == hssm_pkg::HSSM_SBY_DLY) && (mode_reg != hssm_pkg::HSSM_SBY_DLY);
   assign retry_start = (mode_next == hssm_pkg::HSSM_FAULT) && (mode_reg != hssm_pkg::HSSM_FAULT);

   hssm_timer u_stby (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .start_in(stby_start),
      .load_in(hssm_pkg::CNT_W'(STBY_CYC)),
      .done_out(stby_done)
   );

   hssm_timer u_retry (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .start_in(retry_start),
      .load_in(hssm_pkg::CNT_W'(RETRY_CYC)),
      .done_out(retry_done)
   );

   // ****************************************
   // switch drive and sense settling
   // ****************************************
   logic switch_reg;
   logic [hssm_pkg::CNT_W-1:0] settle_reg;

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         switch_reg <= 1'b0;
      end else begin
         switch_reg <= (mode_next == hssm_pkg::HSSM_ACTIVE);
      end
   end

   // tells the host when a sample taken now would be settled
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         settle_reg <= '0;
      end else if (!switch_reg) begin
         settle_reg <= hssm_pkg::CNT_W'(hssm_pkg::SENSE_SETTLE_CYC);
      end else if (settle_reg != '0) begin
         settle_reg <= settle_reg - 1'b1;
      end
   end

   // ****************************************
   // fault indication
   // ****************************************
   logic diag_window;
   logic ol_fault_reg;
   logic fault_detect;
   logic diag_on;

   // open-load check only while disabled with diagnostics on; it follows the
   // present level, so a recovered output drops the indication at once
   assign diag_window = diag_s && !req_s && (mode_reg == hssm_pkg::HSSM_DIAG);

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         ol_fault_reg <= 1'b0;
      end else if (diag_fall || req_rise) begin
         ol_fault_reg <= 1'b0;
      end else begin
         ol_fault_reg <= diag_window && ol_s;
      end
   end

   assign fault_detect = (mode_reg == hssm_pkg::HSSM_FAULT) || ol_fault_reg;
   assign diag_on = diag_s && (mode_reg == hssm_pkg::HSSM_DIAG || mode_reg == hssm_pkg::HSSM_ACTIVE
                               || mode_reg == hssm_pkg::HSSM_FAULT);

   logic sense_en_reg;
   logic [1:0] sense_sel_reg;
   logic flag_oe_reg;

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         sense_en_reg <= 1'b0;
         sense_sel_reg <= hssm_pkg::SNS_NONE;
      end else if (!diag_on) begin
         sense_en_reg <= 1'b0;
         sense_sel_reg <= hssm_pkg::SNS_NONE;
      end else if (sel_s && !FIXED_LIMIT) begin
         sense_en_reg <= 1'b1;
         sense_sel_reg <= hssm_pkg::SNS_TEMP;
      end else if (fault_detect) begin
         sense_en_reg <= 1'b1;
         sense_sel_reg <= hssm_pkg::SNS_FAULT;
      end else begin
         sense_en_reg <= 1'b1;
         sense_sel_reg <= hssm_pkg::SNS_CURRENT;
      end
   end

   // the flag is only ever pulled low; the board pull-up supplies the high
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         flag_oe_reg <= 1'b0;
      end else begin
         flag_oe_reg <= FIXED_LIMIT && diag_on && fault_detect;
      end
   end

   assign switch_on_out = switch_reg;
   assign mode_out = mode_reg;
   assign sense_output_en_out = sense_en_reg;
   assign sense_sel_out = sense_sel_reg;
   assign sense_valid_out = switch_reg && (settle_reg == '0);
   assign fault_flag_output_out = 1'b0;
   assign fault_flag_output_oe_out = flag_oe_reg;
endmodule
`default_nettype wire

// >>> tb/hssm_monitor.sv
// checker for the mode state machine, watching only the top ports
// assumes one clock domain; pins pass a two-flop synchroniser before the modes react
`timescale 1ns/1ps
`default_nettype none
module hssm_monitor #(
   parameter int STBY_CYC = 20,
   parameter int RETRY_CYC = 30
) (
   input wire logic clk_in, // clock
   input wire logic rst_n_in, // reset
   input wire logic supply_ok_in, // supply
   input wire logic gnd_ok_in, // ground
   input wire logic switch_on_req_in, // request
   input wire logic diag_enable_input_in, // diag enable
   input wire logic latch_in, // latch
   input wire logic sense_source_select_in, // select
   input wire logic thermal_sd_in, // thermal
   input wire logic current_limit_in, // limit
   input wire logic open_load_in, // open load
   input wire logic reverse_current_in, // reverse
   input wire logic switch_on_out, // gate
   input wire logic [5:0] mode_out, // mode
   input wire logic sense_output_en_out, // sense drive
   input wire logic [1:0] sense_sel_out, // sense source
   input wire logic sense_valid_out, // settled
   input wire logic fault_flag_output_out, // flag level
   input wire logic fault_flag_output_oe_out // flag pull
);
   // ****************************************
   // helper counters
   // ****************************************
   logic ok;
   int dly_cnt_reg;
   int flt_cnt_reg;
   assign ok = supply_ok_in && gnd_ok_in;
   always_ff @(posedge clk_in) begin
      dly_cnt_reg <= (!rst_n_in || mode_out != hssm_pkg::HSSM_SBY_DLY) ? 0 : dly_cnt_reg + 1;
   end
   always_ff @(posedge clk_in) begin
      flt_cnt_reg <= (!rst_n_in || mode_out != hssm_pkg::HSSM_FAULT) ? 0 : flt_cnt_reg + 1;
   end
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   // ****************************************
   // assertions
   // ****************************************
   chk_switch_active: assert property (switch_on_out == (mode_out == hssm_pkg::HSSM_ACTIVE))
      else $error("switch drive disagrees with mode");
   chk_supply_off: assert property (!supply_ok_in [*3] |=> mode_out == hssm_pkg::HSSM_OFF)
      else $error("mode not off without supply");
   chk_fault_entry: assert property (
      (ok && (thermal_sd_in || current_limit_in) && mode_out == hssm_pkg::HSSM_ACTIVE) [*3]
      |=> mode_out == hssm_pkg::HSSM_FAULT)
      else $error("shutdown did not enter fault");
   chk_latch_hold: assert property (
      (ok && latch_in && mode_out == hssm_pkg::HSSM_FAULT) [*3] |=> mode_out == hssm_pkg::HSSM_FAULT)
      else $error("fault left while latch high");
   chk_retry_min: assert property (
      $fell(mode_out == hssm_pkg::HSSM_FAULT) && mode_out != hssm_pkg::HSSM_OFF
      |-> flt_cnt_reg >= RETRY_CYC - 1)
      else $error("fault left before retry time");
   chk_fault_exit: assert property (
      $fell(mode_out == hssm_pkg::HSSM_FAULT) && mode_out != hssm_pkg::HSSM_OFF
      |-> switch_on_out == $past(switch_on_req_in, 3))
      else $error("switch after fault disagrees with request");
   chk_sense_hiz: assert property (!diag_enable_input_in [*4] |=> !sense_output_en_out)
      else $error("sense driven with diag low");
   chk_standby_quiet: assert property (
      mode_out == hssm_pkg::HSSM_STANDBY |-> !sense_output_en_out && !fault_flag_output_oe_out)
      else $error("standby reports something");
   chk_flag_fault: assert property (
      (mode_out == hssm_pkg::HSSM_FAULT && diag_enable_input_in) [*4]
      |=> fault_flag_output_oe_out && !fault_flag_output_out)
      else $error("flag not pulled low in fault");
   chk_standby_delay: assert property (
      $rose(mode_out == hssm_pkg::HSSM_STANDBY) |-> dly_cnt_reg >= STBY_CYC - 1)
      else $error("standby entered before delay");
endmodule
bind hssm_top hssm_monitor #(.STBY_CYC(STBY_CYC), .RETRY_CYC(RETRY_CYC)) hssm_monitor_inst (.*);
`default_nettype wire

// >>> tb/hssm_host.sv
// host controller model: drives the control pins, reads the sense timing and the flag wire
// assumes the caller changes pins 1 ns after a rising edge
`timescale 1ns/1ps
`default_nettype none
module hssm_host (
   input wire logic clk_in, // clock
   input wire logic switch_on_in, // gate drive
   input wire logic sense_valid_in, // sense settled
   input wire logic flag_oe_in, // flag pull-down
   output logic req_out, // switch-on request
   output logic diag_out, // diag enable
   output logic latch_out, // latch
   output logic sel_out, // sense select
   output logic flag_level_out // flag wire level
);
   int on_cnt = 0;
   int settle_cnt = 0;
   initial begin
      req_out = 1'b0;
      diag_out = 1'b0;
      latch_out = 1'b0;
      sel_out = 1'b0;
   end
   task automatic set_ctrl(input logic r, input logic d, input logic l, input logic s);
      req_out = r;
      diag_out = d;
      latch_out = l;
      sel_out = s;
   endtask
   // board pull-up makes the released flag read high
   assign flag_level_out = flag_oe_in ? 1'b0 : 1'b1;
   // the adc only takes a sample once the sense has settled after turn-on
   always @(posedge clk_in) begin
      on_cnt <= switch_on_in ? on_cnt + 1 : 0;
      if (sense_valid_in && settle_cnt == 0) begin
         settle_cnt <= on_cnt;
      end
   end
endmodule
`default_nettype wire

// >>> tb/hssm_top_test.sv
// self-checking bench for hssm_top with a host model on the control pins
// assumes shortened standby and retry counts; pins move 1 ns after a rising edge
`timescale 1ns/1ps
`default_nettype none
module hssm_top_test;
   localparam int STBY = 20;
   localparam int RETRY = 30;
   logic clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic sup = 1'b0;
   logic gnd = 1'b0;
   logic th = 1'b0;
   logic cl = 1'b0;
   logic ol = 1'b0;
   logic rc = 1'b0;
   logic req, diag, latch, sel, flag_level, sw, sense_en, sense_valid, flag_out, flag_oe;
   logic [5:0] mode;
   logic [1:0] ssel;
   int mismatches = 0;
   int comparisons = 0;
   hssm_pkg::hssm_mode_t exp_mode = hssm_pkg::HSSM_OFF;
   hssm_top #(.STBY_CYC(STBY), .RETRY_CYC(RETRY), .FIXED_LIMIT(1'b1)) hssm_top_inst (.clk_in(clk_in),
      .rst_n_in(rst_n_in), .supply_ok_in(sup), .gnd_ok_in(gnd), .switch_on_req_in(req),
      .diag_enable_input_in(diag), .latch_in(latch), .sense_source_select_in(sel), .thermal_sd_in(th),
      .current_limit_in(cl), .open_load_in(ol), .reverse_current_in(rc), .switch_on_out(sw), .mode_out(mode),
      .sense_output_en_out(sense_en), .sense_sel_out(ssel), .sense_valid_out(sense_valid),
      .fault_flag_output_out(flag_out), .fault_flag_output_oe_out(flag_oe));
   hssm_host hssm_host_inst (.clk_in(clk_in), .switch_on_in(sw), .sense_valid_in(sense_valid),
      .flag_oe_in(flag_oe), .req_out(req), .diag_out(diag), .latch_out(latch), .sel_out(sel),
      .flag_level_out(flag_level));
   initial begin
      forever #50 clk_in = ~clk_in;
   end
   // ****************************************
   // checking and reference model
   // ****************************************
   task automatic check(input string what, input logic [5:0] seen, input logic [5:0] expected);
      comparisons++;
      if (seen !== expected) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, expected, seen);
      end
   endtask
   task automatic give_verdict();
      if (mismatches == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   function automatic hssm_pkg::hssm_mode_t model(input hssm_pkg::hssm_mode_t cur, input bit long_wait);
      if (!sup || !gnd) return hssm_pkg::HSSM_OFF;
      if (cur == hssm_pkg::HSSM_ACTIVE && (th || cl)) return hssm_pkg::HSSM_FAULT;
      if (cur == hssm_pkg::HSSM_FAULT && (th || cl || latch || !long_wait)) return hssm_pkg::HSSM_FAULT;
      if (req) return hssm_pkg::HSSM_ACTIVE;
      if (diag) return hssm_pkg::HSSM_DIAG;
      return long_wait ? hssm_pkg::HSSM_STANDBY : hssm_pkg::HSSM_SBY_DLY;
   endfunction
   // settles for cyc cycles, then compares mode, switch, sense enable and select, and flag level with the model
   task automatic step(input int cyc);
      logic en;
      logic [1:0] s;
      exp_mode = model(exp_mode, cyc >= 60);
      repeat (cyc) @(posedge clk_in);
      #1;
      en = diag && exp_mode inside {hssm_pkg::HSSM_DIAG, hssm_pkg::HSSM_ACTIVE, hssm_pkg::HSSM_FAULT};
      s = (exp_mode == hssm_pkg::HSSM_FAULT || (exp_mode == hssm_pkg::HSSM_DIAG && ol)) ?
          hssm_pkg::SNS_FAULT : hssm_pkg::SNS_CURRENT;
      check("mode", mode, exp_mode);
      check("switch", sw, exp_mode == hssm_pkg::HSSM_ACTIVE);
      check("sense_en", sense_en, en);
      if (en) check("sense_sel", ssel, s);
      check("flag_level", flag_level, !(en && s == hssm_pkg::SNS_FAULT));
   endtask
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      void'($urandom(44));
      repeat (20) @(posedge clk_in);
      #1;
      rst_n_in = 1'b1;
      step(5);
      sup = 1'b1;
      gnd = 1'b1;
      step(8);
      step(60);
      hssm_host_inst.set_ctrl(1'b0, 1'b1, 1'b0, 1'b0);
      ol = 1'b1;
      step(8);
      hssm_host_inst.set_ctrl(1'b0, 1'b0, 1'b0, 1'b0);
      step(8);
      hssm_host_inst.set_ctrl(1'b0, 1'b1, 1'b0, 1'b1);
      step(8);
      hssm_host_inst.set_ctrl(1'b1, 1'b1, 1'b0, 1'b1);
      step(8);
      hssm_host_inst.set_ctrl(1'b1, 1'b0, 1'b0, 1'b0);
      ol = 1'b0;
      step(8);
      hssm_host_inst.set_ctrl(1'b1, 1'b1, 1'b0, 1'b0);
      // reverse current toggles freely while the sense settles
      repeat (1600) begin
         @(posedge clk_in);
         #1;
         rc = 1'($urandom);
      end
      check("settle", hssm_host_inst.settle_cnt >= hssm_pkg::SENSE_SETTLE_CYC - 2 &&
            hssm_host_inst.settle_cnt <= hssm_pkg::SENSE_SETTLE_CYC + 2, 1'b1);
      step(1);
      for (int i = 0; i < 4; i++) begin
         th = 1'($urandom);
         cl = !th;
         step(10);
         hssm_host_inst.set_ctrl(1'b1, 1'(i == 1), 1'b1, 1'b0);
         th = 1'b0;
         cl = 1'b0;
         step(60);
         hssm_host_inst.set_ctrl(1'($urandom), diag, 1'b0, 1'b0);
         step(80);
         hssm_host_inst.set_ctrl(1'b1, 1'b0, 1'b0, 1'b0);
         step(10);
      end
      gnd = 1'b0;
      step(8);
      gnd = 1'b1;
      step(10);
      sup = 1'b0;
      step(8);
      give_verdict();
   end
   initial begin
      repeat (6000) @(posedge clk_in);
      mismatches++;
      give_verdict();
   end
endmodule
`default_nettype wire
